// ---- core/osc_loop_pkg.sv ----
package osc_loop_pkg;

   // register offsets on the serial port's byte address space
   localparam logic [7:0] OSC_CONTROL_ADDR   = 8'h0e;
   localparam logic [7:0] OSC_LEVEL_ADDR     = 8'h0f;
   localparam logic [7:0] OSC_BAND_ADDR      = 8'h10;
   localparam logic [7:0] SPARE_ADDR         = 8'h11;
   localparam logic [7:0] FB_HIGH_ADDR       = 8'h12;
   localparam logic [7:0] FB_MID_ADDR        = 8'h13;
   localparam logic [7:0] FB_LOW_CTRL_ADDR   = 8'h14;
   localparam logic [7:0] OUT1_HIGH_ADDR     = 8'h15;
   localparam logic [7:0] OUT_SHARED_ADDR    = 8'h16;
   localparam logic [7:0] OUT2_LOW_TEST_ADDR = 8'h17;

   // osc_control bit positions
   localparam int CAL_BIT       = 7;
   localparam int AMP_LOOP_BIT  = 6;
   localparam int THR_MSB       = 5;
   localparam int THR_LSB       = 3;
   localparam int CAL_OVR_BIT   = 2;
   localparam int BOOST_BIT     = 1;
   localparam int BAND_OVR_BIT  = 0;
   // osc_level, osc_band fields
   localparam int LEVEL_MSB     = 7;
   localparam int LEVEL_LSB     = 2;
   localparam int BAND_MSB      = 7;
   localparam int BAND_LSB      = 1;
   // feedback_divide_low_and_control fields
   localparam int FB_LOW_MSB    = 7;
   localparam int FB_LOW_LSB    = 4;
   localparam int FB_OVR_BIT    = 3;
   localparam int OUT_OVR_BIT   = 2;
   localparam int LOOP_RST_BIT  = 0;
   // output_divides_shared and second_output_divide_low_and_test fields
   localparam int OUT1_LOW_MSB  = 7;
   localparam int OUT1_LOW_LSB  = 6;
   localparam int OUT2_HIGH_MSB = 5;
   localparam int OUT2_LOW_MSB  = 7;
   localparam int OUT2_LOW_LSB  = 4;
   localparam int TEST_EN_BIT   = 3;
   localparam int TEST_SEL_MSB  = 2;
   localparam int TEST_SEL_LSB  = 1;

   // reset values
   localparam logic [2:0]  THR_RESET      = 3'h6;
   localparam logic [5:0]  LEVEL_RESET    = 6'h20;
   localparam logic [6:0]  BAND_RESET     = 7'h40;
   localparam logic [19:0] FB_DIV_RESET   = 20'h80000;
   localparam logic [9:0]  OUT1_DIV_RESET = 10'h080;
   localparam logic [9:0]  OUT2_DIV_RESET = 10'h000;

   // supply boost step in millivolts, reported to the analog side as a bit
   localparam int BOOST_MV = 100;

   // one register access from the serial port decoder
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   // settings that steer the oscillator and the loop
   typedef struct packed {
      logic        cal_start;
      logic        amp_loop_auto;
      logic [2:0]  amp_threshold;
      logic [5:0]  amp_level;
      logic        supply_boost;
      logic        band_auto;
      logic [6:0]  band;
      logic [19:0] feedback_divide;
      logic [9:0]  first_output_divide;
      logic [9:0]  second_output_divide;
      logic        loop_reset;
   } osc_ctrl_t;

endpackage : osc_loop_pkg

// ---- core/vco_pll_divider_control_regs.sv ----
`timescale 1ns/1ns
module vco_pll_divider_control_regs (
   input  wire logic                   clk_i,
   input  wire logic                   rst_n_i,
   input  wire osc_loop_pkg::reg_req_t req_i,
   output logic [7:0]                  rdata_o,
   input  wire logic [3:0]             ratio_select_pins_i,
   input  wire logic [5:0]             output_select_pins_i,
   output logic [3:0]                  ratio_select_sync_o,
   output logic [5:0]                  output_select_sync_o,
   input  wire logic [19:0]            table_feedback_divide_i,
   input  wire logic [9:0]             table_first_output_divide_i,
   input  wire logic [9:0]             table_second_output_divide_i,
   input  wire logic                   loop_locked_i,
   input  wire logic [3:0]             test_signals_i,
   output osc_loop_pkg::osc_ctrl_t     ctrl_o,
   output logic                        lock_pin_o
);
   import osc_loop_pkg::*;

   typedef enum logic [1:0] {
      CAL_IDLE  = 2'b01,
      CAL_FIRE  = 2'b10
   } cal_state_t;

   logic [7:0]  ctrl_reg;
   logic [5:0]  level_reg;
   logic [6:0]  band_reg;
   logic [19:0] fb_div_reg;
   logic        fb_ovr_reg;
   logic        out_ovr_reg;
   logic        loop_rst_reg;
   logic [9:0]  out1_reg;
   logic [9:0]  out2_reg;
   logic        test_en_reg;
   logic [1:0]  test_sel_reg;
   logic        cal_req_reg;
   logic        auto_due_reg;
   logic        loop_rst_d_reg;
   cal_state_t  cal_state_reg;
   cal_state_t  cal_state_next;
   logic [9:0]  pins_s1_reg;
   logic [9:0]  pins_s2_reg;
   logic [1:0]  lock_sync_reg;
   logic [7:0]  rd_next;
   logic        wr_ctrl;
   logic        fire;

   function automatic logic hit(input reg_req_t r, input logic [7:0] a);
      hit = r.wr && (r.addr == a);
   endfunction : hit

   assign wr_ctrl = hit(req_i, OSC_CONTROL_ADDR);

   // pins come from outside the clock domain, two stages before use
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pins_s1_reg   <= 10'h000;
         pins_s2_reg   <= 10'h000;
         lock_sync_reg <= 2'h0;
      end else begin
         pins_s1_reg   <= {ratio_select_pins_i, output_select_pins_i};
         pins_s2_reg   <= pins_s1_reg;
         lock_sync_reg <= {lock_sync_reg[0], loop_locked_i};
      end
   end
   assign ratio_select_sync_o  = pins_s2_reg[9:6];
   assign output_select_sync_o = pins_s2_reg[5:0];

   // oscillator control register; calibrate bit is not stored here
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl_reg <= {1'b0, 1'b1, THR_RESET, 3'h0};
      end else if (wr_ctrl) begin
         ctrl_reg <= {1'b0, req_i.wdata[6:0]};
      end
   end

   // level and band fields; low bits are not stored
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         level_reg <= LEVEL_RESET;
         band_reg  <= BAND_RESET;
      end else begin
         if (hit(req_i, OSC_LEVEL_ADDR))
            level_reg <= req_i.wdata[LEVEL_MSB:LEVEL_LSB];
         if (hit(req_i, OSC_BAND_ADDR))
            band_reg <= req_i.wdata[BAND_MSB:BAND_LSB];
      end
   end

   // feedback divide and loop control
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         fb_div_reg   <= FB_DIV_RESET;
         fb_ovr_reg   <= 1'b0;
         out_ovr_reg  <= 1'b0;
         loop_rst_reg <= 1'b0;
      end else begin
         if (hit(req_i, FB_HIGH_ADDR))
            fb_div_reg[19:12] <= req_i.wdata;
         if (hit(req_i, FB_MID_ADDR))
            fb_div_reg[11:4] <= req_i.wdata;
         if (hit(req_i, FB_LOW_CTRL_ADDR)) begin
            fb_div_reg[3:0] <= req_i.wdata[FB_LOW_MSB:FB_LOW_LSB];
            fb_ovr_reg      <= req_i.wdata[FB_OVR_BIT];
            out_ovr_reg     <= req_i.wdata[OUT_OVR_BIT];
            loop_rst_reg    <= req_i.wdata[LOOP_RST_BIT];
         end
      end
   end

   // output divides and test port
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         out1_reg     <= OUT1_DIV_RESET;
         out2_reg     <= OUT2_DIV_RESET;
         test_en_reg  <= 1'b0;
         test_sel_reg <= 2'h0;
      end else begin
         if (hit(req_i, OUT1_HIGH_ADDR))
            out1_reg[9:2] <= req_i.wdata;
         if (hit(req_i, OUT_SHARED_ADDR)) begin
            out1_reg[1:0] <= req_i.wdata[OUT1_LOW_MSB:OUT1_LOW_LSB];
            out2_reg[9:4] <= req_i.wdata[OUT2_HIGH_MSB:0];
         end
         if (hit(req_i, OUT2_LOW_TEST_ADDR)) begin
            out2_reg[3:0] <= req_i.wdata[OUT2_LOW_MSB:OUT2_LOW_LSB];
            test_en_reg   <= req_i.wdata[TEST_EN_BIT];
            test_sel_reg  <= req_i.wdata[TEST_SEL_MSB:TEST_SEL_LSB];
         end
      end
   end

   // manual request latch; a write that lands while a pulse fires wins
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cal_req_reg <= 1'b0;
      end else if (wr_ctrl && req_i.wdata[CAL_BIT] && req_i.wdata[CAL_OVR_BIT]) begin
         cal_req_reg <= 1'b1;
      end else if (fire || !ctrl_reg[CAL_OVR_BIT]) begin
         cal_req_reg <= 1'b0;
      end
   end

   // automatic calibration after reset and after each loop reset release
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         auto_due_reg   <= 1'b1;
         loop_rst_d_reg <= 1'b0;
      end else begin
         loop_rst_d_reg <= loop_rst_reg;
         if (loop_rst_d_reg && !loop_rst_reg)
            auto_due_reg <= 1'b1;
         else if (fire)
            auto_due_reg <= 1'b0;
      end
   end

   // a pulse is held back while the loop sits in reset
   always_comb begin
      cal_state_next = cal_state_reg;
      case (cal_state_reg)
         CAL_IDLE: begin
            if (!loop_rst_reg && (ctrl_reg[CAL_OVR_BIT] ? cal_req_reg : auto_due_reg))
               cal_state_next = CAL_FIRE;
         end
         CAL_FIRE: cal_state_next = CAL_IDLE;
         default:  cal_state_next = CAL_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i)
         cal_state_reg <= CAL_IDLE;
      else
         cal_state_reg <= cal_state_next;
   end
   assign fire = (cal_state_reg == CAL_FIRE);

   // read mux; unmapped and spare addresses read zero
   always_comb begin
      case (req_i.addr)
         OSC_CONTROL_ADDR:   rd_next = {cal_req_reg, ctrl_reg[6:0]};
         OSC_LEVEL_ADDR:     rd_next = {level_reg, 2'h0};
         OSC_BAND_ADDR:      rd_next = {band_reg, 1'b0};
         FB_HIGH_ADDR:       rd_next = fb_div_reg[19:12];
         FB_MID_ADDR:        rd_next = fb_div_reg[11:4];
         FB_LOW_CTRL_ADDR:   rd_next = {fb_div_reg[3:0], fb_ovr_reg, out_ovr_reg,
                                        1'b0, loop_rst_reg};
         OUT1_HIGH_ADDR:     rd_next = out1_reg[9:2];
         OUT_SHARED_ADDR:    rd_next = {out1_reg[1:0], out2_reg[9:4]};
         OUT2_LOW_TEST_ADDR: rd_next = {out2_reg[3:0], test_en_reg, test_sel_reg, 1'b0};
         default:            rd_next = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i)
         rdata_o <= 8'h00;
      else if (req_i.rd)
         rdata_o <= rd_next;
   end

   // effective settings, registered so the analog side sees clean levels
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ctrl_o <= '0;
      end else begin
         ctrl_o.cal_start       <= fire;
         ctrl_o.amp_loop_auto   <= ctrl_reg[AMP_LOOP_BIT];
         ctrl_o.amp_threshold   <= ctrl_reg[THR_MSB:THR_LSB];
         ctrl_o.amp_level       <= level_reg;
         ctrl_o.supply_boost    <= ctrl_reg[BOOST_BIT];
         ctrl_o.band_auto       <= !ctrl_reg[BAND_OVR_BIT];
         ctrl_o.band            <= band_reg;
         ctrl_o.feedback_divide <= fb_ovr_reg ? fb_div_reg : table_feedback_divide_i;
         ctrl_o.first_output_divide  <= out_ovr_reg ? out1_reg
                                                    : table_first_output_divide_i;
         ctrl_o.second_output_divide <= out_ovr_reg ? out2_reg
                                                    : table_second_output_divide_i;
         ctrl_o.loop_reset      <= loop_rst_reg;
      end
   end

   // test signals are fast clocks, so this mux stays combinational
   assign lock_pin_o = test_en_reg ? test_signals_i[test_sel_reg] : lock_sync_reg[1];

   // checks on the calibration sequencer, the source selects, the register fields and the read mux, gathered after the logic they guard
   chk_cal_pulse_one: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ctrl_o.cal_start |=> !ctrl_o.cal_start)
      else $error("calibration start longer than one cycle");
   chk_cal_manual_go: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      wr_ctrl && req_i.wdata[CAL_BIT] && req_i.wdata[CAL_OVR_BIT] && !loop_rst_reg
      && cal_state_reg == CAL_IDLE && cal_state_next == CAL_IDLE
      |=> ##2 ctrl_o.cal_start)
      else $error("manual calibration not started");
   chk_cal_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !ctrl_reg[CAL_OVR_BIT]
      && !(wr_ctrl && req_i.wdata[CAL_BIT] && req_i.wdata[CAL_OVR_BIT])
      |=> !cal_req_reg)
      else $error("calibrate bit held without override");
   chk_cal_readback: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      fire && !wr_ctrl |=> !cal_req_reg)
      else $error("calibrate bit not cleared after start");
   chk_fb_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      1'b1 |=> ctrl_o.feedback_divide == ($past(fb_ovr_reg) ? $past(fb_div_reg)
                                          : $past(table_feedback_divide_i)))
      else $error("feedback divide source wrong");
   chk_out_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !out_ovr_reg |=> ctrl_o.first_output_divide == $past(table_first_output_divide_i))
      else $error("output divide not from table");
   chk_fb_assemble: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      hit(req_i, FB_MID_ADDR) |=> fb_div_reg[11:4] == $past(req_i.wdata))
      else $error("feedback middle byte not stored");
   chk_spare_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      req_i.rd && req_i.addr == SPARE_ADDR |=> rdata_o == 8'h00)
      else $error("spare register not zero");
   chk_lock_pin: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !test_en_reg |-> lock_pin_o == lock_sync_reg[1])
      else $error("lock pin not showing lock");
   chk_test_pin: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      test_en_reg |-> lock_pin_o == test_signals_i[test_sel_reg])
      else $error("lock pin not showing test signal");
   chk_boost_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      1'b1 |=> ctrl_o.supply_boost == $past(ctrl_reg[BOOST_BIT]))
      else $error("supply boost not following its bit");
   // the first cycle of loop reset may still carry a pulse launched just before it
   chk_loop_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      loop_rst_reg && loop_rst_d_reg |-> !fire ##1 !ctrl_o.cal_start)
      else $error("calibration during loop reset");

   // main scenarios the bench is expected to reach

   cov_manual_cal: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      ctrl_reg[CAL_OVR_BIT] && ctrl_o.cal_start);
   cov_auto_cal: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      !ctrl_reg[CAL_OVR_BIT] && ctrl_o.cal_start);
   cov_fb_override: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      fb_ovr_reg && out_ovr_reg);
   cov_test_port: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      test_en_reg && test_sel_reg == 2'h3);
   cov_loop_release: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      loop_rst_d_reg && !loop_rst_reg);

endmodule : vco_pll_divider_control_regs

// ---- testbench/reg_host_model.sv ----
`timescale 1ns/1ns
// host side of the register port, one access at a time
module reg_host_model (
   input  wire logic                   clk_i,
   output osc_loop_pkg::reg_req_t      req_o,
   input  wire logic [7:0]             rdata_i
);
   import osc_loop_pkg::*;

   initial req_o = '0;

   // idle address and data flip so a stale value is never taken for a live one
   task automatic release_bus();
      req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~req_o.addr, wdata: ~req_o.wdata};
   endtask : release_bus

   // request raised after a falling edge, held across the taking rising edge
   task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk_i);
      req_o <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(negedge clk_i);
      release_bus();
   endtask : write_reg

   // read data is registered, so it is settled by the next falling edge
   task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
      @(negedge clk_i);
      req_o <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
      @(negedge clk_i);
      data = rdata_i;
      release_bus();
   endtask : read_reg

endmodule : reg_host_model

// ---- testbench/vco_pll_divider_control_regs_tb_top.sv ----
`timescale 1ns/1ns
module vco_pll_divider_control_regs_tb_top;
   import osc_loop_pkg::*;

   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   reg_req_t    req;
   logic [7:0]  rdata;
   logic [3:0]  ratio_pins = '0;
   logic [5:0]  out_pins = '0;
   logic [19:0] tbl_fb = '0;
   logic [9:0]  tbl1 = '0;
   logic [9:0]  tbl2 = '0;
   logic        locked = 1'b0;
   logic [3:0]  tsig = '0;
   logic [3:0]  ratio_sync;
   logic [5:0]  out_sync;
   osc_ctrl_t   ctrl;
   logic        lock_pin;
   int          n_mismatch = 0;
   int          tests_run = 0;
   int          cycles = 0;
   int          seed = 32'h2e3d6338;
   // register model: stored bits, writable mask, reset image (osc_control..0x18)
   logic [7:0]  rm [14:24];
   logic [7:0]  mask [14:24] = '{8'h7f, 8'hfc, 8'hfe, 8'h00, 8'hff, 8'hff, 8'hfd,
                                 8'hff, 8'hff, 8'hfe, 8'h00};
   logic [7:0]  rst_img [14:24] = '{8'h70, 8'h80, 8'h80, 8'h00, 8'h80, 8'h00,
                                    8'h00, 8'h20, 8'h00, 8'h00, 8'h00};

   always #2 clk_i = ~clk_i;

   vco_pll_divider_control_regs i_dut (
      .clk_i                        (clk_i),
      .rst_n_i                      (rst_n_i),
      .req_i                        (req),
      .rdata_o                      (rdata),
      .ratio_select_pins_i          (ratio_pins),
      .output_select_pins_i         (out_pins),
      .ratio_select_sync_o          (ratio_sync),
      .output_select_sync_o         (out_sync),
      .table_feedback_divide_i      (tbl_fb),
      .table_first_output_divide_i  (tbl1),
      .table_second_output_divide_i (tbl2),
      .loop_locked_i                (locked),
      .test_signals_i               (tsig),
      .ctrl_o                       (ctrl),
      .lock_pin_o                   (lock_pin)
   );

   reg_host_model i_host (
      .clk_i   (clk_i),
      .req_o   (req),
      .rdata_i (rdata)
   );

   task automatic end_sim();
      $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : end_sim

   // a hang is cut short well past the roughly 730 cycles the run needs
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         end_sim();
      end
   end

   task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : check_val

   // every steering field but cal_start against the register model and the pin tables
   task automatic check_ctrl();
      check_val("amp_loop_auto", rm[14][6], ctrl.amp_loop_auto);
      check_val("amp_threshold", rm[14][5:3], ctrl.amp_threshold);
      check_val("amp_level", rm[15][7:2], ctrl.amp_level);
      check_val("supply_boost", rm[14][1], ctrl.supply_boost);
      check_val("band_auto", !rm[14][0], ctrl.band_auto);
      check_val("band", rm[16][7:1], ctrl.band);
      check_val("fb_div", rm[20][3] ? {rm[18], rm[19], rm[20][7:4]} : tbl_fb,
                ctrl.feedback_divide);
      check_val("out1_div", rm[20][2] ? {rm[21], rm[22][7:6]} : tbl1,
                ctrl.first_output_divide);
      check_val("out2_div", rm[20][2] ? {rm[22][5:0], rm[23][7:4]} : tbl2,
                ctrl.second_output_divide);
      check_val("loop_reset", rm[20][0], ctrl.loop_reset);
      check_val("lock_pin", rm[23][3] ? tsig[rm[23][2:1]] : locked, lock_pin);
      check_val("pin_sync", {ratio_pins, out_pins}, {ratio_sync, out_sync});
   endtask : check_ctrl

   task automatic read_all();
      logic [7:0] d;
      for (int a = 14; a <= 24; a++) begin
         i_host.read_reg(a[7:0], d);
         check_val("readback", rm[a], d);
      end
   endtask : read_all

   task automatic count_cal(output int c);
      c = 0;
      repeat (5) begin
         @(negedge clk_i);
         if (ctrl.cal_start === 1'b1) c++;
      end
   endtask : count_cal

   task automatic do_reset();
      @(negedge clk_i);
      rst_n_i = 1'b0;
      repeat (3) @(negedge clk_i);
      rst_n_i = 1'b1;
      rm = rst_img;
   endtask : do_reset

   initial begin
      int         c;
      int         a;
      logic [7:0] d;
      logic [63:0] rnd;
      do_reset();
      count_cal(c);
      check_val("auto_cal", 1, c);
      read_all();
      check_ctrl();
      // manual calibration: one pulse, bit reads back clear
      i_host.write_reg(8'h0e, 8'h84);
      rm[14] = 8'h04;
      count_cal(c);
      check_val("manual_cal", 1, c);
      i_host.read_reg(8'h0e, d);
      check_val("cal_clear", 8'h04, d);
      // calibrate bit with override clear is ignored
      i_host.write_reg(8'h0e, 8'h80);
      rm[14] = 8'h00;
      count_cal(c);
      check_val("cal_ignored", 0, c);
      // loop reset holds, its release brings an automatic calibration
      i_host.write_reg(8'h14, 8'h01);
      rm[20] = 8'h01;
      repeat (2) @(negedge clk_i);
      check_ctrl();
      i_host.write_reg(8'h14, 8'h00);
      rm[20] = 8'h00;
      count_cal(c);
      check_val("release_cal", 1, c);
      // random writes across the map, pins and tables changing beneath
      for (int i = 0; i < 80; i++) begin
         a = 14 + ($unsigned($random(seed)) % 11);
         d = $random(seed);
         if (a == 14) d[7] = 1'b0;
         i_host.write_reg(a[7:0], d);
         rm[a] = d & mask[a];
         rnd = {$random(seed), $random(seed)};
         {ratio_pins, out_pins, tbl_fb, tbl1, tbl2, locked, tsig} = rnd[54:0];
         repeat (4) @(negedge clk_i);
         check_ctrl();
         i_host.read_reg(a[7:0], d);
         check_val("rand_read", rm[a], d);
      end
      // second reset at the end of the run restores every register
      do_reset();
      repeat (5) @(negedge clk_i);
      read_all();
      end_sim();
   end

endmodule : vco_pll_divider_control_regs_tb_top
